// ---- inc/phy_vendor_cfg.svh ----
// Notes on behaviour
// - Read bit copies selected word, then self-clears.
// - Bits 6:0 select advanced word 0 to 12.
// - Read data is read-only, latched, resets zero.
// - Bit 9 enables transmit clock delay.
// - Bit 8 enables receive clock delay.
// - Both delay bits reset to zero, then load from strap once it settles.
// - Read-only bit 4 shows 10M polarity reversal.
// - Flags 10, 9, 8 latch buffer, idle error events.
// - Flag 7 latches on energy detect rising.
// - Flags 6, 5 latch negotiation done, fault.
// - Flags 4, 3 latch link down, partner ack.
// - Flags 2, 1 latch detect fault, page.
// - Mask bits 10 to 8 enable matching flags.
// - Advanced bank accepts no writes at all.
// - Mask bits 7 to 1 enable matching flags.
`ifndef PHY_VENDOR_CFG_SVH
`define PHY_VENDOR_CFG_SVH

// ****************************************
// Register indices
// ****************************************
`define IDX_ADDR_PORT 5'h14
`define IDX_READ_DATA 5'h15
`define IDX_CTRL_STAT 5'h1B
`define IDX_IRQ_FLAGS 5'h1D
`define IDX_IRQ_MASK 5'h1E

// ****************************************
// Field positions
// ****************************************
`define POS_READ_BIT 15
`define POS_RESV_HI 14
`define POS_RESV_LO 7
`define POS_SEL_HI 6
`define POS_TXC_DELAY 9
`define POS_RXC_DELAY 8
`define POS_POLARITY 4
`define POS_FLAG_HI 10
`define POS_FLAG_LO 1

// ****************************************
// Reset values and limits
// ****************************************
`define RST_READ_DATA 16'h0000
`define RST_SEL 7'h00
`define RST_RESV 8'h00
`define RST_FLAGS 10'h000
`define RST_MASK 10'h000
`define ADV_LAST 7'h0C
`define STRAP_SETTLE 2'h3

`endif

// ---- inc/phy_vendor_pkg.sv ----
package phy_vendor_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic txbuf_overflow;
        logic txbuf_underflow;
        logic idle_err_count_ovf;
        logic autoneg_done;
        logic remote_fault;
        logic link_down;
        logic partner_ack;
        logic parallel_detect_fault;
        logic ms_config_fault;
        logic page_received;
    } phy_events_t;

    typedef logic [12:0][15:0] adv_bank_t;

endpackage

// ---- rtl/phy_vendor_regs_indirect_irq.sv ----
`timescale 1ns/10ps
`include "phy_vendor_cfg.svh"

module phy_vendor_regs_indirect_irq
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire phy_vendor_pkg::mgmt_req_t mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    input wire phy_vendor_pkg::adv_bank_t adv_bank,
    output logic [6:0] adv_sel,
    output logic adv_read_pulse,
    input wire phy_vendor_pkg::phy_events_t events,
    input wire logic energy_detected,
    input wire logic rx_polarity_reversed_10m,
    input wire logic internal_delay_strap,
    output logic txc_delay_en,
    output logic rxc_delay_en,
    output logic irq_request
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] sel_word(input phy_vendor_pkg::adv_bank_t bank,
                                             input logic [6:0] idx);
        logic [15:0] w;
        w = 16'h0000;
        // Out of range selections return zero
        if (idx <= `ADV_LAST)
        begin
            w = bank[idx[3:0]];
        end
        return w;
    endfunction

    function automatic logic is_write(input phy_vendor_pkg::mgmt_req_t r,
                                      input logic [4:0] idx);
        return r.wr && (r.addr == idx);
    endfunction

    // ****************************************
    // Strap synchroniser
    // ****************************************
    logic strap_s1;
    logic strap_s2;
    logic strap_s3;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] next_strap_cnt;
    logic next_strap_done;
    logic strap_load;

    always_comb
    begin
        next_strap_cnt = strap_cnt;
        next_strap_done = strap_done;
        strap_load = 1'b0;
        if (!strap_done)
        begin
            if (strap_cnt != `STRAP_SETTLE)
            begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
            // Wait for a settled level before latching
            else if (strap_s2 == strap_s3)
            begin
                strap_load = 1'b1;
                next_strap_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
            strap_s3 <= 1'b0;
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
        end
        else
        begin
            strap_s1 <= internal_delay_strap;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            strap_cnt <= next_strap_cnt;
            strap_done <= next_strap_done;
        end
    end

    // ****************************************
    // Indirect window
    // ****************************************
    logic read_pend;
    logic [7:0] addr_resv;
    logic [15:0] read_data;
    logic next_read_pend;
    logic [7:0] next_addr_resv;
    logic [6:0] next_adv_sel;
    logic [15:0] next_read_data;
    logic next_adv_read_pulse;

    always_comb
    begin
        next_read_pend = read_pend;
        next_addr_resv = addr_resv;
        next_adv_sel = adv_sel;
        next_read_data = read_data;
        next_adv_read_pulse = 1'b0;
        if (read_pend)
        begin
            next_read_data = sel_word(adv_bank, adv_sel);
            next_adv_read_pulse = 1'b1;
            next_read_pend = 1'b0;
        end
        // Data port and bank ignore writes
        if (is_write(mgmt_req, `IDX_ADDR_PORT))
        begin
            next_read_pend = mgmt_req.wdata[`POS_READ_BIT];
            next_addr_resv = mgmt_req.wdata[`POS_RESV_HI:`POS_RESV_LO];
            next_adv_sel = mgmt_req.wdata[`POS_SEL_HI:0];
        end
        if (soft_reset)
        begin
            next_read_pend = 1'b0;
            next_addr_resv = `RST_RESV;
            next_adv_sel = `RST_SEL;
            next_read_data = `RST_READ_DATA;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_pend <= 1'b0;
            addr_resv <= `RST_RESV;
            adv_sel <= `RST_SEL;
            read_data <= `RST_READ_DATA;
            adv_read_pulse <= 1'b0;
        end
        else
        begin
            read_pend <= next_read_pend;
            addr_resv <= next_addr_resv;
            adv_sel <= next_adv_sel;
            read_data <= next_read_data;
            adv_read_pulse <= next_adv_read_pulse;
        end
    end

    // ****************************************
    // Delay enables and interrupt flags
    // ****************************************
    logic [10:1] flags;
    logic [10:1] mask;
    logic energy_prev;
    logic [10:1] ev_vec;
    logic [10:1] next_flags;
    logic [10:1] next_mask;
    logic next_txc;
    logic next_rxc;
    logic next_irq;

    always_comb
    begin
        ev_vec = {events.txbuf_overflow, events.txbuf_underflow,
                  events.idle_err_count_ovf,
                  energy_detected && !energy_prev,
                  events.autoneg_done, events.remote_fault,
                  events.link_down, events.partner_ack,
                  events.parallel_detect_fault || events.ms_config_fault,
                  events.page_received};
        next_flags = flags;
        next_mask = mask;
        next_txc = txc_delay_en;
        next_rxc = rxc_delay_en;
        if (is_write(mgmt_req, `IDX_IRQ_FLAGS))
        begin
            next_flags = flags & ~mgmt_req.wdata[`POS_FLAG_HI:`POS_FLAG_LO];
        end
        // New events beat a clear in the same cycle
        next_flags = next_flags | ev_vec;
        if (is_write(mgmt_req, `IDX_IRQ_MASK))
        begin
            next_mask = mgmt_req.wdata[`POS_FLAG_HI:`POS_FLAG_LO];
        end
        if (is_write(mgmt_req, `IDX_CTRL_STAT))
        begin
            next_txc = mgmt_req.wdata[`POS_TXC_DELAY];
            next_rxc = mgmt_req.wdata[`POS_RXC_DELAY];
        end
        if (strap_load)
        begin
            next_txc = strap_s3;
            next_rxc = strap_s3;
        end
        // Delay bits survive a software reset
        if (soft_reset)
        begin
            next_flags = `RST_FLAGS;
            next_mask = `RST_MASK;
        end
        next_irq = |(next_flags & next_mask);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags <= `RST_FLAGS;
            mask <= `RST_MASK;
            energy_prev <= 1'b0;
            txc_delay_en <= 1'b0;
            rxc_delay_en <= 1'b0;
            irq_request <= 1'b0;
        end
        else
        begin
            flags <= next_flags;
            mask <= next_mask;
            energy_prev <= energy_detected;
            txc_delay_en <= next_txc;
            rxc_delay_en <= next_rxc;
            irq_request <= next_irq;
        end
    end

    // ****************************************
    // Read back
    // ****************************************
    logic [15:0] rb;
    logic [15:0] next_rdata;

    always_comb
    begin
        rb = 16'h0000;
        unique case (mgmt_req.addr)
            `IDX_ADDR_PORT: rb = {read_pend, addr_resv, adv_sel};
            `IDX_READ_DATA: rb = read_data;
            `IDX_CTRL_STAT:
            begin
                rb[`POS_TXC_DELAY] = txc_delay_en;
                rb[`POS_RXC_DELAY] = rxc_delay_en;
                rb[`POS_POLARITY] = rx_polarity_reversed_10m;
            end
            `IDX_IRQ_FLAGS: rb[`POS_FLAG_HI:`POS_FLAG_LO] = flags;
            `IDX_IRQ_MASK: rb[`POS_FLAG_HI:`POS_FLAG_LO] = mask;
            default: rb = 16'h0000;
        endcase
        next_rdata = mgmt_req.rd ? rb : mgmt_rdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end
        else
        begin
            mgmt_rdata <= next_rdata;
            mgmt_rvalid <= mgmt_req.rd;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic wr_addr;
    logic wr_flags;
    logic wr_mask;
    logic [15:0] sel_now;
    assign wr_addr = is_write(mgmt_req, `IDX_ADDR_PORT);
    assign wr_flags = is_write(mgmt_req, `IDX_IRQ_FLAGS);
    assign wr_mask = is_write(mgmt_req, `IDX_IRQ_MASK);
    assign sel_now = sel_word(adv_bank, adv_sel);

    indirect_copy_a: assert property (read_pend && !soft_reset
        |=> read_data == $past(sel_now))
        else $error("indirect copy wrong");
    self_clear_a: assert property (wr_addr && mgmt_req.wdata[15] && !soft_reset
        |=> read_pend ##1 (!read_pend || $past(wr_addr)))
        else $error("read bit not self cleared");
    range_zero_a: assert property (read_pend && adv_sel > `ADV_LAST && !soft_reset
        |=> read_data == 16'h0000)
        else $error("out of range not zero");
    data_ro_a: assert property (!read_pend && !soft_reset |=> $stable(read_data))
        else $error("read data changed");
    strap_load_a: assert property (strap_load
        |=> txc_delay_en == $past(strap_s3) && rxc_delay_en == $past(strap_s3))
        else $error("strap not loaded");
    polarity_rd_a: assert property (mgmt_req.rd && mgmt_req.addr == `IDX_CTRL_STAT
        |=> mgmt_rvalid && mgmt_rdata[4] == $past(rx_polarity_reversed_10m))
        else $error("polarity read wrong");
    buffer_flag_a: assert property (events.txbuf_overflow && !soft_reset
        |=> flags[10])
        else $error("overflow flag missed");
    energy_flag_a: assert property ($rose(energy_detected) && !soft_reset
        |=> flags[7])
        else $error("energy flag missed");
    flag_sticky_a: assert property (flags[5] && !wr_flags && !soft_reset
        |=> flags[5])
        else $error("flag lost");
    irq_level_a: assert property (!soft_reset |=> irq_request == |(flags & mask))
        else $error("irq mismatch");
    irq_event_a: assert property (|(ev_vec & mask) && !wr_mask && !soft_reset
        |=> irq_request)
        else $error("enabled event lost");

    indirect_read_c: cover property (wr_addr && mgmt_req.wdata[15] ##2 mgmt_req.rd);
    irq_rise_c: cover property ($rose(irq_request));
    strap_high_c: cover property (strap_load && strap_s3);
    strap_low_c: cover property (strap_load && !strap_s3);
    flag_clear_c: cover property (flags[1] ##1 wr_flags ##1 !flags[1]);

endmodule

// ---- sim/mgmt_host_model.sv ----
`timescale 1ns/10ps
`include "phy_vendor_cfg.svh"

module mgmt_host_model
(
    input wire logic clk,
    output phy_vendor_pkg::mgmt_req_t mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid
);
    // ****************************************
    // Single-cycle decoded accesses
    // ****************************************
    initial mgmt_req = '0;

    task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        mgmt_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        mgmt_req <= '0;
        #1;
    endtask

    // Answer registered on the taking edge, so look just after it
    task automatic read_reg(input logic [4:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        mgmt_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk);
        mgmt_req <= '0;
        #1;
        d = mgmt_rdata;
        v = mgmt_rvalid;
    endtask

    task automatic adv_read(input logic [6:0] sel, output logic [15:0] d, output logic v);
        write_reg(`IDX_ADDR_PORT, {1'b1, 8'h03, sel});
        read_reg(`IDX_READ_DATA, d, v);
    endtask

    // Flag 7 may be stale after a hardware reset
    task automatic clear_energy_flag();
        write_reg(`IDX_IRQ_FLAGS, 16'h0080);
    endtask
endmodule

// ---- sim/phy_vendor_regs_indirect_irq_tb_top.sv ----
`timescale 1ns/10ps
`include "phy_vendor_cfg.svh"

module phy_vendor_regs_indirect_irq_tb_top;
    logic clk;
    logic rst_n;
    logic soft_reset;
    logic energy_detected;
    logic rx_polarity_reversed_10m;
    logic internal_delay_strap;
    phy_vendor_pkg::mgmt_req_t mgmt_req;
    phy_vendor_pkg::adv_bank_t adv_bank;
    phy_vendor_pkg::phy_events_t events;
    logic [15:0] mgmt_rdata;
    logic mgmt_rvalid;
    logic txc_delay_en;
    logic rxc_delay_en;
    logic irq_request;
    logic [6:0] adv_sel;
    logic adv_read_pulse;
    int pulse_count = 0;
    int fails = 0;
    int check_count = 0;

    mgmt_host_model u_host (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata),
        .mgmt_rvalid(mgmt_rvalid));

    phy_vendor_regs_indirect_irq DUT (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
        .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
        .adv_bank(adv_bank), .adv_sel(adv_sel), .adv_read_pulse(adv_read_pulse),
        .events(events),
        .energy_detected(energy_detected), .rx_polarity_reversed_10m(rx_polarity_reversed_10m),
        .internal_delay_strap(internal_delay_strap), .txc_delay_en(txc_delay_en),
        .rxc_delay_en(rxc_delay_en), .irq_request(irq_request));

    // ****************************************
    // Helpers
    // ****************************************
    // Counted off the edge so the pulse has settled
    always @(negedge clk)
    begin
        if (adv_read_pulse === 1'b1)
        begin
            pulse_count++;
        end
    end

    function automatic logic [15:0] word_of(input int i);
        return {4'hA, 4'(i), 8'h3C};
    endfunction

    // Two event sources share flag 2
    function automatic int flag_of(input int i);
        return (i >= 7) ? i + 1 : (i <= 1) ? i + 1 : i;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        logic v;
        u_host.read_reg(a, d, v);
        chk({15'h0000, v}, 16'h0001);
    endtask

    task automatic pulse_event(input logic [9:0] v);
        @(posedge clk);
        events <= phy_vendor_pkg::phy_events_t'(v);
        @(posedge clk);
        events <= '0;
        #1;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [15:0] d;
        rd(`IDX_READ_DATA, d);
        chk(d, 16'h0000);
        rd(`IDX_IRQ_FLAGS, d);
        chk(d, 16'h0000);
        rd(`IDX_IRQ_MASK, d);
        chk(d, 16'h0000);
        rd(`IDX_CTRL_STAT, d);
        chk(d, 16'h0300);
        chk({14'h0000, txc_delay_en, rxc_delay_en}, 16'h0003);
    endtask

    task automatic t_indirect();
        logic [15:0] d;
        logic v;
        for (int s = 13; s >= 0; s--)
        begin
            u_host.adv_read(7'(s), d, v);
            chk(d, (s < 13) ? word_of(s) : 16'h0000);
            chk({9'h000, adv_sel}, 16'(s));
            chk(16'(pulse_count), 16'(14 - s));
            rd(`IDX_ADDR_PORT, d);
            chk(d & 16'h807F, 16'(s));
        end
        u_host.write_reg(`IDX_ADDR_PORT, 16'h0185);
        u_host.write_reg(`IDX_READ_DATA, 16'hFFFF);
        rd(`IDX_READ_DATA, d);
        chk(d, word_of(0));
    endtask

    task automatic t_ctrl();
        logic [15:0] d;
        logic [15:0] vals [4] = '{16'h0000, 16'h0200, 16'h0100, 16'h0310};
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            rx_polarity_reversed_10m <= k[0];
            u_host.write_reg(`IDX_CTRL_STAT, vals[k]);
            rd(`IDX_CTRL_STAT, d);
            chk(d, (vals[k] & 16'h0300) | {11'h000, k[0], 4'h0});
            chk({14'h0000, txc_delay_en, rxc_delay_en}, 16'(vals[k][9:8]));
        end
    endtask

    task automatic t_flags();
        logic [15:0] d;
        for (int i = 0; i < 10; i++)
        begin
            pulse_event(10'h001 << i);
            rd(`IDX_IRQ_FLAGS, d);
            chk(d, 16'h0001 << flag_of(i));
            u_host.write_reg(`IDX_IRQ_FLAGS, 16'h0001 << flag_of(i));
            rd(`IDX_IRQ_FLAGS, d);
            chk(d, 16'h0000);
        end
        @(posedge clk);
        energy_detected <= 1'b1;
        rd(`IDX_IRQ_FLAGS, d);
        chk(d, 16'h0080);
        u_host.clear_energy_flag();
        rd(`IDX_IRQ_FLAGS, d);
        chk(d, 16'h0000);
        @(posedge clk);
        energy_detected <= 1'b0;
    endtask

    task automatic t_irq();
        u_host.write_reg(`IDX_IRQ_MASK, 16'h0400);
        pulse_event(10'h200);
        chk({15'h0000, irq_request}, 16'h0001);
        u_host.write_reg(`IDX_IRQ_MASK, 16'h0000);
        chk({15'h0000, irq_request}, 16'h0000);
        u_host.write_reg(`IDX_IRQ_MASK, 16'h0002);
        pulse_event(10'h001);
        chk({15'h0000, irq_request}, 16'h0001);
        u_host.write_reg(`IDX_IRQ_FLAGS, 16'h0402);
        chk({15'h0000, irq_request}, 16'h0000);
    endtask

    task automatic t_soft();
        logic [15:0] d;
        logic v;
        u_host.write_reg(`IDX_CTRL_STAT, 16'h0200);
        u_host.write_reg(`IDX_IRQ_MASK, 16'h07FE);
        rd(`IDX_IRQ_MASK, d);
        chk(d, 16'h07FE);
        u_host.adv_read(7'h03, d, v);
        chk(d, word_of(3));
        chk({15'h0000, v}, 16'h0001);
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        rd(`IDX_IRQ_MASK, d);
        chk(d, 16'h0000);
        rd(`IDX_READ_DATA, d);
        chk(d, 16'h0000);
        rd(`IDX_ADDR_PORT, d);
        chk(d & 16'h807F, 16'h0000);
        chk({14'h0000, txc_delay_en, rxc_delay_en}, 16'h0002);
    endtask

    // Strap low, and a write before the strap load is overruled
    task automatic t_hw_reset();
        logic [15:0] d;
        u_host.write_reg(`IDX_IRQ_MASK, 16'h07FE);
        @(posedge clk);
        internal_delay_strap <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        u_host.write_reg(`IDX_CTRL_STAT, 16'h0300);
        chk({14'h0000, txc_delay_en, rxc_delay_en}, 16'h0003);
        repeat (3) @(posedge clk);
        rd(`IDX_CTRL_STAT, d);
        chk(d, 16'h0010);
        chk({14'h0000, txc_delay_en, rxc_delay_en}, 16'h0000);
        rd(`IDX_IRQ_MASK, d);
        chk(d, 16'h0000);
        u_host.clear_energy_flag();
        rd(`IDX_IRQ_FLAGS, d);
        chk(d, 16'h0000);
    endtask

    // ****************************************
    // Run control
    // ****************************************
    task automatic test_done();
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        #100000;
        fails++;
        test_done();
    end

    initial
    begin
        rst_n = 1'b0;
        soft_reset = 1'b0;
        energy_detected = 1'b0;
        rx_polarity_reversed_10m = 1'b0;
        internal_delay_strap = 1'b1;
        events = '0;
        for (int i = 0; i < 13; i++)
            adv_bank[i] = word_of(i);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_indirect();
        t_ctrl();
        t_flags();
        t_irq();
        t_soft();
        t_hw_reset();
        test_done();
    end
endmodule
